/* rcw_pkg.sv */
// Constants, types and register map of the reset and configuration core
package rcw_pkg;

  // ***************************************************************
  // Widths and clock
  // ***************************************************************
  localparam int unsigned ADDR_W        = 6;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned CFG_W         = 12;
  localparam int unsigned PC_W          = 9;
  localparam int unsigned DIR_W         = 4;
  localparam int unsigned CLK_SYS_HZ    = 25_000_000;
  localparam int unsigned INT_OSC_HZ    = 4_000_000;

  // ***************************************************************
  // Register indexes and byte addresses
  // ***************************************************************
  localparam logic [ADDR_W-1:0] IDX_STATUS   = 6'h03;
  localparam logic [ADDR_W-1:0] IDX_OSC_TRIM = 6'h05;
  localparam logic [ADDR_W-1:0] IDX_CMP_CTRL = 6'h07;
  localparam logic [ADDR_W-1:0] IDX_PIN_DIR  = 6'h08;
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = 6'(IDX_STATUS * 4);
  localparam logic [ADDR_W-1:0] ADDR_OSC_TRIM = 6'(IDX_OSC_TRIM * 4);
  localparam logic [ADDR_W-1:0] ADDR_CMP_CTRL = 6'(IDX_CMP_CTRL * 4);
  localparam logic [ADDR_W-1:0] ADDR_PIN_DIR  = 6'(IDX_PIN_DIR * 4);

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int unsigned ST_PIN_WAKE   = 7;
  localparam int unsigned ST_CMP_WAKE   = 6;
  localparam int unsigned ST_EXPIRY_N   = 4;
  localparam int unsigned ST_SLEEP_N    = 3;
  localparam int unsigned ST_ALU_MSB    = 2;
  localparam int unsigned CC_RESULT     = 7;
  localparam int unsigned CC_ENABLE     = 3;
  localparam int unsigned CC_WAKE_EN_N  = 0;
  localparam int unsigned CFG_RESET_PIN = 4;
  localparam int unsigned CFG_READ_LOCK = 3;
  localparam int unsigned CFG_WDT_EN    = 2;
  localparam logic [CFG_W-1:0] CFG_IMPL_MASK = 12'h01C;

  // ***************************************************************
  // Reset values and program addresses
  // ***************************************************************
  localparam logic [DATA_W-1:0] STATUS_POR   = 8'h18;
  localparam logic [DATA_W-1:0] OSC_TRIM_POR = 8'hFE;
  localparam logic [DATA_W-1:0] CMP_CTRL_POR = 8'hFF;
  localparam logic [DIR_W-1:0]  PIN_DIR_RST  = 4'hF;
  localparam logic [PC_W-1:0]   PC_LAST      = 9'h0FF;
  localparam logic [PC_W-1:0]   PC_START     = 9'h000;
  localparam logic [3:0]        LIT_OPCODE   = 4'hC;

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic [2:0] {
    CAUSE_POWER_UP,
    CAUSE_EXT_RUN,
    CAUSE_EXT_SLEEP,
    CAUSE_WDT_RUN,
    CAUSE_WDT_SLEEP,
    CAUSE_PIN_WAKE,
    CAUSE_CMP_WAKE
  } rcw_cause_type;

  typedef enum logic [1:0] {
    SEQ_HOLD,
    SEQ_CAL,
    SEQ_RUN
  } rcw_seq_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } rcw_bus_req_type;

  typedef struct packed {
    logic reset_pin_select;
    logic read_lock;
    logic watchdog_enable;
  } rcw_cfg_type;

endpackage : rcw_pkg

/* rcw_cmp_wake.sv */
// Comparator change detector for wake from sleep
`timescale 1ns/10ps
module rcw_cmp_wake (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  input  wire logic latch_i,
  input  wire logic comparator_result_i,
  input  wire logic comparator_wake_enable_n_i,
  input  wire logic asleep_i,
  output logic      change_o
);

  logic latched_r;
  logic armed_r;

  // ***************************************************************
  // Latch on read, arm until a change is reported
  // ***************************************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latched_r <= 1'b1;
      armed_r   <= 1'b0;
    end else if (latch_i) begin
      latched_r <= comparator_result_i;
      armed_r   <= 1'b1;
    end else if (change_o) begin
      armed_r   <= 1'b0;
    end
  end

  assign change_o = armed_r && asleep_i && !comparator_wake_enable_n_i &&
                    (comparator_result_i != latched_r);

endmodule : rcw_cmp_wake

/* rcw_core.sv */
// Reset cause, configuration decode and wake state core
//
// Operation
// - Enabled comparator keeps running in sleep; only software disable or a reset stops it.
// - Power-up loads comparator control with all ones.
// - Comparator is powered down throughout any reset interval.
// - Configuration word is twelve bits wide and decoded into options.
// - Configuration bits 11 to 5 and 1 to 0 read as zero.
// - Bit 4 makes shared pin an external reset, else I/O with reset inactive.
// - Read protection is on when configuration bit 3 is zero.
// - Watchdog enable comes only from configuration bit 2.
// - Configuration word has no run-time address.
// - System clock comes only from the trimmed internal oscillator; here clk_sys_i is an input at CLK_SYS_HZ (25 MHz), not the 4 MHz oscillator.
// - After reset fetch calibration literal at last address, then start at zero.
// - Calibration location stays readable despite read protection.
// - Oscillator trim register value trims the oscillator.
// - Seven reset causes are told apart.
// - Some registers keep their value over all resets but power-up.
// - Registers restore on power-up and running resets and wake on pin or comparator change.
// - External or watchdog reset in sleep leaves registers untouched but pin direction, which reloads all ones.
// - Status flags are set or cleared per reset cause.
// - Power-up, running and sleeping external reset load their status patterns.
// - Watchdog expiry in sleep or running loads its status pattern.
// - Pin and comparator wake load patterns setting their wake flag.
// - Comparator wake flag sets on a change after a latching read in sleep.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
module rcw_core (
  input  wire logic                          clk_sys_i,
  input  wire logic                          rst_n_i,
  input  wire rcw_pkg::rcw_bus_req_type      bus_req_i,
  output logic [rcw_pkg::DATA_W-1:0]         bus_rdata_o,
  input  wire logic [rcw_pkg::CFG_W-1:0]     config_word_i,
  input  wire logic                          ext_reset_pin_i,
  input  wire logic                          watchdog_expiry_i,
  input  wire logic                          pin_change_i,
  input  wire logic                          comparator_result_i,
  input  wire logic                          sleep_enter_i,
  input  wire logic [11:0]                   instr_word_i,
  input  wire logic [rcw_pkg::PC_W-1:0]      prog_rd_addr_i,
  output logic                               prog_rd_allow_o,
  output logic [rcw_pkg::PC_W-1:0]           fetch_addr_o,
  output logic [rcw_pkg::DATA_W-1:0]         cal_value_o,
  output logic                               cal_valid_o,
  output logic                               core_reset_o,
  output logic                               restore_regs_o,
  output rcw_pkg::rcw_cause_type             reset_cause_o,
  output logic                               wake_request_o,
  output logic                               asleep_o,
  output logic                               int_reset_n_o,
  output logic                               pin_io_mode_o,
  output logic                               read_lock_o,
  output logic                               watchdog_enable_o,
  output logic [rcw_pkg::CFG_W-1:0]          config_value_o,
  output logic [rcw_pkg::DATA_W-1:0]         osc_trim_o,
  output logic                               comparator_power_o,
  output logic [rcw_pkg::DATA_W-2:0]         comparator_control_o,
  output logic [rcw_pkg::DIR_W-1:0]          pin_direction_o
);

  rcw_pkg::rcw_seq_type              seq_r;
  rcw_pkg::rcw_cause_type            cause_r;
  rcw_pkg::rcw_cause_type            cause_nxt;
  rcw_pkg::rcw_cfg_type              cfg_r;
  logic                              cfg_loaded_r;
  logic [rcw_pkg::CFG_W-1:0]         cfg_word_r;
  logic                              asleep_r;
  logic [rcw_pkg::DATA_W-1:0]        status_r;
  logic [rcw_pkg::DATA_W-1:0]        osc_trim_r;
  logic [rcw_pkg::DATA_W-2:0]        cmp_ctrl_r;
  logic [rcw_pkg::DIR_W-1:0]         pin_dir_r;
  logic [rcw_pkg::DATA_W-1:0]        rdata_r;
  logic [rcw_pkg::PC_W-1:0]          pc_r;
  logic [rcw_pkg::DATA_W-1:0]        cal_r;
  logic                              cal_valid_r;
  logic                              restore_r;
  logic                              ext_low;
  logic                              wdt_hit;
  logic                              pin_hit;
  logic                              cmp_hit;
  logic                              reset_evt;
  logic                              running;
  logic                              cmp_latch;

  localparam int unsigned ST_PIN_WAKE_L = rcw_pkg::ST_PIN_WAKE;
  localparam int unsigned ST_CMP_WAKE_L = rcw_pkg::ST_CMP_WAKE;

  // ***************************************************************
  // Configuration capture after power-up release
  // ***************************************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_loaded_r <= 1'b0;
      cfg_word_r   <= '0;
      cfg_r        <= '0;
    end else if (!cfg_loaded_r) begin
      cfg_loaded_r           <= 1'b1;
      cfg_word_r             <= config_word_i & rcw_pkg::CFG_IMPL_MASK;
      cfg_r.reset_pin_select <= config_word_i[rcw_pkg::CFG_RESET_PIN];
      cfg_r.read_lock        <= !config_word_i[rcw_pkg::CFG_READ_LOCK];
      cfg_r.watchdog_enable  <= config_word_i[rcw_pkg::CFG_WDT_EN];
    end
  end

  assign config_value_o    = cfg_word_r;
  assign read_lock_o       = cfg_r.read_lock;
  assign watchdog_enable_o = cfg_r.watchdog_enable;
  assign pin_io_mode_o     = !cfg_r.reset_pin_select;
  assign int_reset_n_o     = cfg_r.reset_pin_select ? ext_reset_pin_i : 1'b1;
  assign prog_rd_allow_o   = !cfg_r.read_lock ||
                             (prog_rd_addr_i == rcw_pkg::PC_LAST);

  // ***************************************************************
  // Reset cause detection
  // ***************************************************************
  assign running   = (seq_r != rcw_pkg::SEQ_HOLD);
  assign ext_low   = cfg_loaded_r && cfg_r.reset_pin_select && !ext_reset_pin_i;
  assign wdt_hit   = watchdog_expiry_i && cfg_r.watchdog_enable;
  assign pin_hit   = pin_change_i && asleep_r;
  assign reset_evt = running && (ext_low || wdt_hit || pin_hit || cmp_hit);
  assign wake_request_o = running && asleep_r && (pin_hit || cmp_hit);

  always_comb begin
    if (ext_low) begin
      cause_nxt = asleep_r ? rcw_pkg::CAUSE_EXT_SLEEP : rcw_pkg::CAUSE_EXT_RUN;
    end else if (wdt_hit) begin
      cause_nxt = asleep_r ? rcw_pkg::CAUSE_WDT_SLEEP : rcw_pkg::CAUSE_WDT_RUN;
    end else if (pin_hit) begin
      cause_nxt = rcw_pkg::CAUSE_PIN_WAKE;
    end else begin
      cause_nxt = rcw_pkg::CAUSE_CMP_WAKE;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cause_r <= rcw_pkg::CAUSE_POWER_UP;
    end else if (reset_evt) begin
      cause_r <= cause_nxt;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      restore_r <= 1'b0;
    end else begin
      restore_r <= reset_evt && (cause_nxt != rcw_pkg::CAUSE_EXT_SLEEP) &&
                   (cause_nxt != rcw_pkg::CAUSE_WDT_SLEEP);
    end
  end

  // ***************************************************************
  // Sleep state
  // ***************************************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      asleep_r <= 1'b0;
    end else if (reset_evt) begin
      asleep_r <= 1'b0;
    end else if (sleep_enter_i && seq_r == rcw_pkg::SEQ_RUN) begin
      asleep_r <= 1'b1;
    end
  end

  // ***************************************************************
  // Reset vector sequencer
  // ***************************************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seq_r <= rcw_pkg::SEQ_HOLD;
    end else begin
      case (seq_r)
        rcw_pkg::SEQ_HOLD: begin
          if (cfg_loaded_r && !ext_low) begin
            seq_r <= rcw_pkg::SEQ_CAL;
          end
        end
        rcw_pkg::SEQ_CAL: begin
          seq_r <= reset_evt ? rcw_pkg::SEQ_HOLD : rcw_pkg::SEQ_RUN;
        end
        default: begin
          if (reset_evt) begin
            seq_r <= rcw_pkg::SEQ_HOLD;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pc_r <= rcw_pkg::PC_LAST;
    end else if (seq_r == rcw_pkg::SEQ_HOLD) begin
      pc_r <= rcw_pkg::PC_LAST;
    end else if (seq_r == rcw_pkg::SEQ_CAL) begin
      pc_r <= rcw_pkg::PC_START;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cal_r       <= '0;
      cal_valid_r <= 1'b0;
    end else if (seq_r == rcw_pkg::SEQ_HOLD) begin
      cal_valid_r <= 1'b0;
    end else if (seq_r == rcw_pkg::SEQ_CAL) begin
      if (instr_word_i[11:8] == rcw_pkg::LIT_OPCODE) begin
        cal_r       <= instr_word_i[7:0];
        cal_valid_r <= 1'b1;
      end
    end
  end

  // ***************************************************************
  // Core status register
  // ***************************************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_r <= rcw_pkg::STATUS_POR;
    end else if (reset_evt) begin
      status_r[ST_PIN_WAKE_L:ST_CMP_WAKE_L] <= 2'h0;
      case (cause_nxt)
        rcw_pkg::CAUSE_EXT_SLEEP: begin
          status_r[rcw_pkg::ST_EXPIRY_N] <= 1'b1;
          status_r[rcw_pkg::ST_SLEEP_N]  <= 1'b0;
        end
        rcw_pkg::CAUSE_WDT_SLEEP: begin
          status_r[rcw_pkg::ST_EXPIRY_N] <= 1'b0;
          status_r[rcw_pkg::ST_SLEEP_N]  <= 1'b0;
        end
        rcw_pkg::CAUSE_WDT_RUN: begin
          status_r[rcw_pkg::ST_EXPIRY_N] <= 1'b0;
        end
        rcw_pkg::CAUSE_PIN_WAKE: begin
          status_r[rcw_pkg::ST_PIN_WAKE] <= 1'b1;
          status_r[rcw_pkg::ST_EXPIRY_N] <= 1'b1;
          status_r[rcw_pkg::ST_SLEEP_N]  <= 1'b0;
        end
        rcw_pkg::CAUSE_CMP_WAKE: begin
          status_r[rcw_pkg::ST_CMP_WAKE] <= 1'b1;
          status_r[rcw_pkg::ST_EXPIRY_N] <= 1'b1;
          status_r[rcw_pkg::ST_SLEEP_N]  <= 1'b0;
        end
        default: begin
        end
      endcase
    end else if (sleep_enter_i && seq_r == rcw_pkg::SEQ_RUN && !asleep_r) begin
      status_r[rcw_pkg::ST_EXPIRY_N] <= 1'b1;
      status_r[rcw_pkg::ST_SLEEP_N]  <= 1'b0;
    end else if (bus_req_i.wr && bus_req_i.addr == rcw_pkg::ADDR_STATUS) begin
      status_r[ST_PIN_WAKE_L:ST_CMP_WAKE_L] <= bus_req_i.wdata[ST_PIN_WAKE_L:ST_CMP_WAKE_L];
      status_r[rcw_pkg::ST_ALU_MSB:0]       <= bus_req_i.wdata[rcw_pkg::ST_ALU_MSB:0];
    end
  end

  // ***************************************************************
  // Trim, comparator and pin direction registers
  // ***************************************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_trim_r <= rcw_pkg::OSC_TRIM_POR;
    end else if (bus_req_i.wr && bus_req_i.addr == rcw_pkg::ADDR_OSC_TRIM) begin
      osc_trim_r <= bus_req_i.wdata;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmp_ctrl_r <= rcw_pkg::CMP_CTRL_POR[rcw_pkg::DATA_W-2:0];
    end else if (bus_req_i.wr && bus_req_i.addr == rcw_pkg::ADDR_CMP_CTRL) begin
      cmp_ctrl_r <= bus_req_i.wdata[rcw_pkg::DATA_W-2:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_dir_r <= rcw_pkg::PIN_DIR_RST;
    end else if (seq_r == rcw_pkg::SEQ_HOLD) begin
      pin_dir_r <= rcw_pkg::PIN_DIR_RST;
    end else if (bus_req_i.wr && bus_req_i.addr == rcw_pkg::ADDR_PIN_DIR) begin
      pin_dir_r <= bus_req_i.wdata[rcw_pkg::DIR_W-1:0];
    end
  end

  assign osc_trim_o           = osc_trim_r;
  assign comparator_control_o = cmp_ctrl_r;
  assign comparator_power_o   = cmp_ctrl_r[rcw_pkg::CC_ENABLE] && running;
  assign pin_direction_o      = pin_dir_r;

  // ***************************************************************
  // Comparator wake detector
  // ***************************************************************
  assign cmp_latch = bus_req_i.rd && bus_req_i.addr == rcw_pkg::ADDR_CMP_CTRL;

  rcw_cmp_wake u_cmp_wake (
    .clk_sys_i                  (clk_sys_i),
    .rst_n_i                    (rst_n_i),
    .latch_i                    (cmp_latch),
    .comparator_result_i        (comparator_result_i),
    .comparator_wake_enable_n_i (cmp_ctrl_r[rcw_pkg::CC_WAKE_EN_N]),
    .asleep_i                   (asleep_r),
    .change_o                   (cmp_hit)
  );

  // ***************************************************************
  // Register read port
  // ***************************************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= '0;
    end else if (bus_req_i.rd) begin
      if (bus_req_i.addr == rcw_pkg::ADDR_STATUS) begin
        rdata_r <= status_r & 8'hDF;
      end else if (bus_req_i.addr == rcw_pkg::ADDR_OSC_TRIM) begin
        rdata_r <= osc_trim_r;
      end else if (bus_req_i.addr == rcw_pkg::ADDR_CMP_CTRL) begin
        rdata_r <= {comparator_result_i, cmp_ctrl_r};
      end else begin
        rdata_r <= '0;
      end
    end else begin
      rdata_r <= '0;
    end
  end

  assign bus_rdata_o    = rdata_r;
  assign fetch_addr_o   = pc_r;
  assign cal_value_o    = cal_r;
  assign cal_valid_o    = cal_valid_r;
  assign core_reset_o   = !running;
  assign restore_regs_o = restore_r;
  assign reset_cause_o  = cause_r;
  assign asleep_o       = asleep_r;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  property p_cmp_sleep;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (asleep_r && cmp_ctrl_r[rcw_pkg::CC_ENABLE] && running) |-> comparator_power_o;
  endproperty
  a_cmp_sleep: assert property (p_cmp_sleep) else $error("comparator off in sleep");

  property p_cmp_reset;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    core_reset_o |-> !comparator_power_o;
  endproperty
  a_cmp_reset: assert property (p_cmp_reset) else $error("comparator on in reset");

  property p_cfg_zero;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (config_value_o & ~rcw_pkg::CFG_IMPL_MASK) == 12'h000;
  endproperty
  a_cfg_zero: assert property (p_cfg_zero) else $error("unused config bit set");

  property p_lock;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    cfg_loaded_r |-> (read_lock_o == !config_value_o[rcw_pkg::CFG_READ_LOCK]);
  endproperty
  a_lock: assert property (p_lock) else $error("read lock polarity wrong");

  property p_wdt_off;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (seq_r == rcw_pkg::SEQ_RUN && watchdog_expiry_i && !watchdog_enable_o &&
     !ext_low && !pin_hit && !cmp_hit) |=> (seq_r == rcw_pkg::SEQ_RUN);
  endproperty
  a_wdt_off: assert property (p_wdt_off) else $error("disabled watchdog reset");

  property p_cal_seq;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (seq_r == rcw_pkg::SEQ_CAL) |-> (fetch_addr_o == rcw_pkg::PC_LAST)
      ##1 (fetch_addr_o == rcw_pkg::PC_START);
  endproperty
  a_cal_seq: assert property (p_cal_seq) else $error("reset vector order wrong");

  property p_ext_sleep;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (reset_evt && ext_low && asleep_r) |=> (status_r[7:3] == 5'h02);
  endproperty
  a_ext_sleep: assert property (p_ext_sleep) else $error("sleep reset status wrong");

  property p_pin_wake;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (reset_evt && cause_nxt == rcw_pkg::CAUSE_PIN_WAKE) |=> (status_r[7:3] == 5'h12);
  endproperty
  a_pin_wake: assert property (p_pin_wake) else $error("pin wake status wrong");

  property p_keep_sleep;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (reset_evt && (cause_nxt == rcw_pkg::CAUSE_EXT_SLEEP ||
     cause_nxt == rcw_pkg::CAUSE_WDT_SLEEP)) |=> !restore_regs_o;
  endproperty
  a_keep_sleep: assert property (p_keep_sleep) else $error("sleep reset restored");

  property p_wake_req;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    wake_request_o |=> core_reset_o ##1 (seq_r != rcw_pkg::SEQ_RUN);
  endproperty
  a_wake_req: assert property (p_wake_req) else $error("wake did not reset core");

endmodule : rcw_core

/* rcw_core_tb.sv */
// Self-checking bench of the reset and configuration core
`timescale 1ns/10ps
module rcw_core_tb;
  logic                     clk_sys_i = 1'b0, rst_n_i = 1'b0, sleep_enter_i = 1'b0;
  logic                     ext_reset_pin_i = 1'b1, watchdog_expiry_i = 1'b0;
  logic                     pin_change_i = 1'b0, comparator_result_i = 1'b0;
  rcw_pkg::rcw_bus_req_type bus_req_i = '0;
  logic [11:0]              config_word_i = 12'hFFF, instr_word_i = 12'hCA5, config_value_o;
  logic [8:0]               prog_rd_addr_i = 9'h0FF, fetch_addr_o;
  logic [7:0]               bus_rdata_o, cal_value_o, osc_trim_o;
  logic                     prog_rd_allow_o, cal_valid_o, core_reset_o, restore_regs_o;
  logic                     asleep_o, int_reset_n_o, pin_io_mode_o, read_lock_o;
  logic                     watchdog_enable_o, comparator_power_o, wake_request_o;
  logic [6:0]               comparator_control_o;
  logic [3:0]               pin_direction_o;
  rcw_pkg::rcw_cause_type   reset_cause_o;
  int                       err_count = 0, check_count = 0;

  rcw_core u_rcw_core (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bus_req_i(bus_req_i),
    .bus_rdata_o(bus_rdata_o), .config_word_i(config_word_i), .ext_reset_pin_i(ext_reset_pin_i),
    .watchdog_expiry_i(watchdog_expiry_i), .pin_change_i(pin_change_i),
    .comparator_result_i(comparator_result_i), .sleep_enter_i(sleep_enter_i),
    .instr_word_i(instr_word_i), .prog_rd_addr_i(prog_rd_addr_i),
    .prog_rd_allow_o(prog_rd_allow_o), .fetch_addr_o(fetch_addr_o), .cal_value_o(cal_value_o),
    .cal_valid_o(cal_valid_o), .core_reset_o(core_reset_o), .restore_regs_o(restore_regs_o),
    .reset_cause_o(reset_cause_o), .wake_request_o(wake_request_o), .asleep_o(asleep_o),
    .int_reset_n_o(int_reset_n_o), .pin_io_mode_o(pin_io_mode_o), .read_lock_o(read_lock_o),
    .watchdog_enable_o(watchdog_enable_o), .config_value_o(config_value_o),
    .osc_trim_o(osc_trim_o), .comparator_power_o(comparator_power_o),
    .comparator_control_o(comparator_control_o), .pin_direction_o(pin_direction_o));

  always #20 clk_sys_i = ~clk_sys_i;

  // ***************************************************************
  // Tasks
  // ***************************************************************
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_run;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk_sys_i);
      #1;
      if (core_reset_o === 1'b0 && fetch_addr_o === rcw_pkg::PC_START) return;
    end
    err_count++;
    test_done;
  endtask : wait_run
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus_req_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys_i);
    bus_req_i <= '0;
    #1;
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    bus_req_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys_i);
    bus_req_i <= '0;
    #1;
    chk(bus_rdata_o, e);
  endtask : rd
  task automatic ev(input bit slp, input int k, input logic [7:0] st,
                    input rcw_pkg::rcw_cause_type c, input logic rs);
    if (slp) begin
      sleep_enter_i <= 1'b1;
      @(posedge clk_sys_i);
      sleep_enter_i <= 1'b0;
      @(posedge clk_sys_i);
      #1;
      chk({asleep_o, comparator_power_o}, 2'h3);
    end
    case (k)
      0: ext_reset_pin_i <= 1'b0;
      1: watchdog_expiry_i <= 1'b1;
      2: pin_change_i <= 1'b1;
      default: comparator_result_i <= ~comparator_result_i;
    endcase
    #1;
    chk(wake_request_o, k >= 2);
    @(posedge clk_sys_i);
    ext_reset_pin_i <= 1'b1;
    watchdog_expiry_i <= 1'b0;
    pin_change_i <= 1'b0;
    #1;
    chk(reset_cause_o, c);
    chk(restore_regs_o, rs);
    chk(comparator_power_o, 1'b0);
    wait_run;
    rd(rcw_pkg::ADDR_STATUS, st);
  endtask : ev

  // ***************************************************************
  // Sequence
  // ***************************************************************
  initial begin
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    wait_run;
    chk(config_value_o, 12'h01C);
    chk({read_lock_o, watchdog_enable_o, pin_io_mode_o, int_reset_n_o}, 4'h5);
    chk({cal_valid_o, cal_value_o}, 9'h1A5);
    rd(rcw_pkg::ADDR_STATUS, 8'h18);
    rd(rcw_pkg::ADDR_OSC_TRIM, 8'hFE);
    rd(rcw_pkg::ADDR_CMP_CTRL, 8'h7F);
    rd(6'h3C, 8'h00);
    wr(rcw_pkg::ADDR_OSC_TRIM, 8'h5A);
    wr(rcw_pkg::ADDR_STATUS, 8'h07);
    rd(rcw_pkg::ADDR_OSC_TRIM, 8'h5A);
    chk(osc_trim_o, 8'h5A);
    rd(rcw_pkg::ADDR_STATUS, 8'h1F);
    wr(rcw_pkg::ADDR_PIN_DIR, 8'h05);
    chk(pin_direction_o, 4'h5);
    $display("test config done");
    ev(1'b1, 2, 8'h97, rcw_pkg::CAUSE_PIN_WAKE, 1'b1);
    chk(pin_direction_o, 4'hF);
    ev(1'b0, 0, 8'h17, rcw_pkg::CAUSE_EXT_RUN, 1'b1);
    ev(1'b0, 1, 8'h07, rcw_pkg::CAUSE_WDT_RUN, 1'b1);
    ev(1'b1, 1, 8'h07, rcw_pkg::CAUSE_WDT_SLEEP, 1'b0);
    ev(1'b1, 0, 8'h17, rcw_pkg::CAUSE_EXT_SLEEP, 1'b0);
    rd(rcw_pkg::ADDR_CMP_CTRL, 8'h7F);
    wr(rcw_pkg::ADDR_CMP_CTRL, 8'h7E);
    ev(1'b1, 3, 8'h57, rcw_pkg::CAUSE_CMP_WAKE, 1'b1);
    chk(comparator_control_o, 7'h7E);
    rd(rcw_pkg::ADDR_OSC_TRIM, 8'h5A);
    $display("test events done");
    config_word_i <= 12'h000;
    rst_n_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    wait_run;
    chk({config_value_o, read_lock_o, watchdog_enable_o, pin_io_mode_o}, 12'h005);
    chk(prog_rd_allow_o, 1'b1);
    rd(rcw_pkg::ADDR_STATUS, 8'h18);
    rd(rcw_pkg::ADDR_CMP_CTRL, 8'hFF);
    prog_rd_addr_i <= 9'h010;
    ext_reset_pin_i <= 1'b0;
    watchdog_expiry_i <= 1'b1;
    @(posedge clk_sys_i);
    watchdog_expiry_i <= 1'b0;
    @(posedge clk_sys_i);
    #1;
    chk({prog_rd_allow_o, int_reset_n_o, core_reset_o}, 3'h2);
    $display("test second power-up done");
    test_done;
  end
endmodule : rcw_core_tb
